// file: design/dpo_cfg.svh
// constants for the dual output modulator and counter compare block
`ifndef DPO_CFG_SVH
`define DPO_CFG_SVH
// clock rate in hertz
`define DPO_CLK_HZ 32'd20000000
// duty full scale
`define DPO_DUTY_FULL 32'd32000
// register offsets (byte address, word index = byte address / 4)
`define DPO_OFS_CTRL 8'h00
`define DPO_OFS_STATUS 8'h04
`define DPO_OFS_PRESET1 8'h08
`define DPO_OFS_PRESET2 8'h0c
`define DPO_OFS_DUTY1 8'h10
`define DPO_OFS_FREQ1 8'h14
`define DPO_OFS_DUTY2 8'h18
`define DPO_OFS_FREQ2 8'h1c
`define DPO_OFS_STOP_DUTY1 8'h20
`define DPO_OFS_STOP_FREQ1 8'h24
`define DPO_OFS_STOP_DUTY2 8'h28
`define DPO_OFS_STOP_FREQ2 8'h2c
`define DPO_OFS_CPR1 8'h30
`define DPO_OFS_CPR2 8'h34
`define DPO_OFS_CNT_CTRL 8'h38
`define DPO_OFS_ACC1 8'h40
`define DPO_OFS_ACC2 8'h44
`define DPO_OFS_ACC3 8'h48
`define DPO_OFS_ACC4 8'h4c
// control register fields
`define DPO_CTRL_MODE1_LSB 0
`define DPO_CTRL_MODE2_LSB 2
`define DPO_CTRL_PLAIN1_BIT 4
`define DPO_CTRL_PLAIN2_BIT 5
`define DPO_CTRL_EN1_BIT 6
`define DPO_CTRL_EN2_BIT 7
`define DPO_CTRL_HOLD1_BIT 8
`define DPO_CTRL_HOLD2_BIT 9
`define DPO_CTRL_QUAD1_BIT 10
`define DPO_CTRL_QUAD2_BIT 11
`define DPO_CTRL_RESET 32'h00000000
`define DPO_REG_RESET 32'h00000000
`endif

// file: design/dpo_pkg.sv
// types shared by the dual output modulator block
package dpo_pkg;
   typedef enum logic [1:0] {
      DPO_MODE_PLAIN,
      DPO_MODE_PWM,
      DPO_MODE_CMP,
      DPO_MODE_RSVD
   } dpo_mode_t;

   // software register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dpo_bus_req_t;

   // settings handed to one modulator
   typedef struct packed {
      logic [31:0] duty;
      logic [31:0] freq;
   } dpo_pwm_set_t;
endpackage

// file: design/dpo_pwm_gen.sv
// one pulse width modulator channel
`timescale 1ns/1ps
`default_nettype none
`include "dpo_cfg.svh"
module dpo_pwm_gen (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire dpo_pkg::dpo_pwm_set_t set_i,
   output logic pwm_o
);
   import dpo_pkg::*;

   logic [31:0] cnt_ff;
   logic [31:0] period_ff;
   logic [31:0] high_ff;
   logic [31:0] duty_sat;
   logic [63:0] prod;
   logic pwm_ff;

   // saturate duty above full scale
   assign duty_sat = (set_i.duty > `DPO_DUTY_FULL) ? `DPO_DUTY_FULL : set_i.duty; // RULE14
   assign prod = 64'(period_ff) * 64'(duty_sat);

   // period and high time recomputed from settings; divide is slow but settings change rarely
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         period_ff <= 32'h00000000;
         high_ff <= 32'h00000000;
      end else begin
         period_ff <= (set_i.freq == 32'h0) ? 32'h0 : `DPO_CLK_HZ / set_i.freq; // RULE7
         high_ff <= 32'(prod / 64'(`DPO_DUTY_FULL)); // RULE5
      end
   end

   // free running period counter
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_ff <= 32'h00000000;
      end else if (!en_i || period_ff <= 32'h00000001 || cnt_ff >= period_ff - 32'h00000001) begin
         cnt_ff <= 32'h00000000;
      end else begin
         cnt_ff <= cnt_ff + 32'h00000001;
      end
   end

   // zero duty or frequency keeps the pin low; full duty keeps it high at any nonzero frequency
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pwm_ff <= 1'b0;
      end else if (!en_i || set_i.duty == 32'h00000000 || set_i.freq == 32'h00000000) begin
         pwm_ff <= 1'b0; // RULE8
      end else if (duty_sat == `DPO_DUTY_FULL) begin
         pwm_ff <= 1'b1; // RULE6
      end else begin
         pwm_ff <= (cnt_ff < high_ff);
      end
   end
   assign pwm_o = pwm_ff;
endmodule
`default_nettype wire

// file: design/dpo_cmp.sv
// counter compare of one accumulator against its preset
`timescale 1ns/1ps
`default_nettype none
`include "dpo_cfg.svh"
module dpo_cmp (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic [31:0] acc_i,
   input wire logic [31:0] preset_i,
   output logic cmp_o
);
   import dpo_pkg::*;
   logic cmp_ff;

   // zero preset disables the compare; output high once count reaches preset
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmp_ff <= 1'b0;
      end else begin
         cmp_ff <= (preset_i != 32'h00000000) && (acc_i >= preset_i); // RULE12
      end
   end
   assign cmp_o = cmp_ff;
endmodule
`default_nettype wire

// file: design/dpo_top.sv
// dual output block: plain, modulated or counter compare drive on two pins
// ==========================================
// Overview of operation
// RULE1 - each output selects plain, modulated or compare
// RULE2 - compare mode drives from accumulator versus preset
// RULE3 - plain mode drives pin from output bit
// RULE4 - two modulators, separate enables and settings
// RULE5 - duty 32-bit, high fraction duty over full scale
// RULE6 - zero duty off, full scale always on
// RULE7 - frequency in hertz, period its reciprocal
// RULE8 - output low until period and duty nonzero
// RULE9 - stop mode holds last or uses stop settings
// RULE10 - zero stop period or duty keeps low
// RULE11 - four bits clear counters or set quadrature
// RULE12 - zero preset disables compare, output low
// RULE13 - quadrature set loads counts per revolution minus one
// RULE14 - high time period times duty over scale, saturated
`timescale 1ns/1ps
`default_nettype none
`include "dpo_cfg.svh"
module dpo_top (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire dpo_pkg::dpo_bus_req_t bus_i,
   output logic [31:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic [3:0] cnt_inc_i,
   output logic output_channel_one_o,
   output logic output_channel_two_o
);
   import dpo_pkg::*;

   // ==========================================
   // register file
   logic [31:0] ctrl_ff;
   logic [31:0] preset_ff [2];
   logic [31:0] duty_ff [2];
   logic [31:0] freq_ff [2];
   logic [31:0] sduty_ff [2];
   logic [31:0] sfreq_ff [2];
   logic [31:0] cpr_ff [2];
   logic [3:0] cnt_ctl_ff;
   logic [31:0] acc_ff [4];
   logic [31:0] rdata_ff;
   logic [3:0] inc_s1_ff;
   logic [3:0] inc_s2_ff;
   logic [3:0] inc_d_ff;
   logic [1:0] pwm_raw;
   logic [1:0] cmp_raw;
   logic [1:0] hold_ff;
   logic [1:0] pin_ff;
   logic [1:0] pwm_en;
   logic stop_s1_ff;
   logic stop_s2_ff;
   dpo_pwm_set_t pwm_set [2];

   function automatic dpo_mode_t mode_of(input logic [1:0] f);
      mode_of = dpo_mode_t'(f);
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = bus_i.wr && (a == o);
   endfunction

   // software writes; counter controls are self clearing pulses
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_ff <= `DPO_CTRL_RESET;
         cnt_ctl_ff <= 4'h0;
         for (int i = 0; i < 2; i++) begin
            preset_ff[i] <= `DPO_REG_RESET;
            duty_ff[i] <= `DPO_REG_RESET;
            freq_ff[i] <= `DPO_REG_RESET;
            sduty_ff[i] <= `DPO_REG_RESET;
            sfreq_ff[i] <= `DPO_REG_RESET;
            cpr_ff[i] <= `DPO_REG_RESET;
         end
      end else begin
         cnt_ctl_ff <= 4'h0;
         if (hit(bus_i.addr, `DPO_OFS_CTRL)) ctrl_ff <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_PRESET1)) preset_ff[0] <= bus_i.wdata; // RULE12
         if (hit(bus_i.addr, `DPO_OFS_PRESET2)) preset_ff[1] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_DUTY1)) duty_ff[0] <= bus_i.wdata; // RULE5
         if (hit(bus_i.addr, `DPO_OFS_FREQ1)) freq_ff[0] <= bus_i.wdata; // RULE7
         if (hit(bus_i.addr, `DPO_OFS_DUTY2)) duty_ff[1] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_FREQ2)) freq_ff[1] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_STOP_DUTY1)) sduty_ff[0] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_STOP_FREQ1)) sfreq_ff[0] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_STOP_DUTY2)) sduty_ff[1] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_STOP_FREQ2)) sfreq_ff[1] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_CPR1)) cpr_ff[0] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_CPR2)) cpr_ff[1] <= bus_i.wdata;
         if (hit(bus_i.addr, `DPO_OFS_CNT_CTRL)) cnt_ctl_ff <= bus_i.wdata[3:0]; // RULE11
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= 32'h00000000;
      end else if (bus_i.rd) begin
         case (bus_i.addr)
            `DPO_OFS_CTRL: rdata_ff <= ctrl_ff;
            `DPO_OFS_STATUS: rdata_ff <= {26'h0, stop_s2_ff, hold_ff, pin_ff, 1'b0};
            `DPO_OFS_PRESET1: rdata_ff <= preset_ff[0];
            `DPO_OFS_PRESET2: rdata_ff <= preset_ff[1];
            `DPO_OFS_DUTY1: rdata_ff <= duty_ff[0];
            `DPO_OFS_FREQ1: rdata_ff <= freq_ff[0];
            `DPO_OFS_DUTY2: rdata_ff <= duty_ff[1];
            `DPO_OFS_FREQ2: rdata_ff <= freq_ff[1];
            `DPO_OFS_STOP_DUTY1: rdata_ff <= sduty_ff[0];
            `DPO_OFS_STOP_FREQ1: rdata_ff <= sfreq_ff[0];
            `DPO_OFS_STOP_DUTY2: rdata_ff <= sduty_ff[1];
            `DPO_OFS_STOP_FREQ2: rdata_ff <= sfreq_ff[1];
            `DPO_OFS_CPR1: rdata_ff <= cpr_ff[0];
            `DPO_OFS_CPR2: rdata_ff <= cpr_ff[1];
            `DPO_OFS_ACC1: rdata_ff <= acc_ff[0];
            `DPO_OFS_ACC2: rdata_ff <= acc_ff[1];
            `DPO_OFS_ACC3: rdata_ff <= acc_ff[2];
            `DPO_OFS_ACC4: rdata_ff <= acc_ff[3];
            default: rdata_ff <= 32'h00000000;
         endcase
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end
   assign rdata_o = rdata_ff;

   // ==========================================
   // counter accumulators
   // count pulses arrive from pins, so two flops before edge detection
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         inc_s1_ff <= 4'h0;
         inc_s2_ff <= 4'h0;
         inc_d_ff <= 4'h0;
         stop_s1_ff <= 1'b0;
         stop_s2_ff <= 1'b0;
      end else begin
         inc_s1_ff <= cnt_inc_i;
         inc_s2_ff <= inc_s1_ff;
         inc_d_ff <= inc_s2_ff;
         stop_s1_ff <= stop_mode_i;
         stop_s2_ff <= stop_s1_ff;
      end
   end

   // odd control bits load counts per revolution minus one into the even accumulator of a
   // quadrature pair; each accumulator has one process, clear beats set, both beat a count
   for (genvar k = 0; k < 4; k++) begin : g_acc
      localparam int QI = k / 2;
      if ((k % 2) == 0) begin : g_even
         always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               acc_ff[k] <= 32'h00000000;
            end else if (cnt_ctl_ff[k]) begin
               acc_ff[k] <= 32'h00000000; // RULE11
            end else if (cnt_ctl_ff[k + 1] && ctrl_ff[`DPO_CTRL_QUAD1_BIT + QI]) begin
               acc_ff[k] <= cpr_ff[QI] - 32'h00000001; // RULE13
            end else if (inc_s2_ff[k] && !inc_d_ff[k]) begin
               acc_ff[k] <= acc_ff[k] + 32'h00000001;
            end
         end
      end else begin : g_odd
         // in a quadrature pair this bit sets the partner, so this counter keeps its count
         always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               acc_ff[k] <= 32'h00000000;
            end else if (cnt_ctl_ff[k] && !ctrl_ff[`DPO_CTRL_QUAD1_BIT + QI]) begin
               acc_ff[k] <= 32'h00000000; // RULE11
            end else if (inc_s2_ff[k] && !inc_d_ff[k]) begin
               acc_ff[k] <= acc_ff[k] + 32'h00000001;
            end
         end
      end
   end

   // ==========================================
   // output channels
   for (genvar c = 0; c < 2; c++) begin : g_ch
      // run settings, or stop settings in stop mode
      assign pwm_set[c].duty = stop_s2_ff ? sduty_ff[c] : duty_ff[c]; // RULE9
      assign pwm_set[c].freq = stop_s2_ff ? sfreq_ff[c] : freq_ff[c]; // RULE10
      assign pwm_en[c] = ctrl_ff[`DPO_CTRL_EN1_BIT + c]; // RULE4

      dpo_pwm_gen u_pwm (
         .clk_sys_i(clk_sys_i),
         .rstn_i(rstn_i),
         .en_i(pwm_en[c]),
         .set_i(pwm_set[c]),
         .pwm_o(pwm_raw[c])
      ); // RULE8 RULE6 RULE14

      dpo_cmp u_cmp (
         .clk_sys_i(clk_sys_i),
         .rstn_i(rstn_i),
         .acc_i(acc_ff[c]),
         .preset_i(preset_ff[c]),
         .cmp_o(cmp_raw[c])
      ); // RULE2

      // hold flag latched while stop mode with hold configured
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
         if (!rstn_i) begin
            hold_ff[c] <= 1'b0;
         end else begin
            hold_ff[c] <= stop_s2_ff && ctrl_ff[`DPO_CTRL_HOLD1_BIT + c];
         end
      end

      // pin mux; holding freezes the modulated level
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
         if (!rstn_i) begin
            pin_ff[c] <= 1'b0;
         end else begin
            case (mode_of(ctrl_ff[`DPO_CTRL_MODE1_LSB + 2 * c +: 2])) // RULE1
               DPO_MODE_PLAIN: pin_ff[c] <= ctrl_ff[`DPO_CTRL_PLAIN1_BIT + c]; // RULE3
               DPO_MODE_PWM: pin_ff[c] <= hold_ff[c] ? pin_ff[c] : pwm_raw[c]; // RULE9
               DPO_MODE_CMP: pin_ff[c] <= cmp_raw[c]; // RULE12
               default: pin_ff[c] <= 1'b0;
            endcase
         end
      end
   end

   assign output_channel_one_o = pin_ff[0];
   assign output_channel_two_o = pin_ff[1];

   // ==========================================
   // checks
   sequence s_preset_zero;
      preset_ff[0] == 32'h00000000;
   endsequence

   property p_cmp_off;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      s_preset_zero ##1 s_preset_zero |=> !cmp_raw[0];
   endproperty
   a_cmp_off: assert property (p_cmp_off) else $error("compare high with zero preset"); // RULE12

   property p_plain;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ctrl_ff[1:0] == 2'b00) |=> (output_channel_one_o == $past(ctrl_ff[`DPO_CTRL_PLAIN1_BIT]));
   endproperty
   a_plain: assert property (p_plain) else $error("plain mode pin mismatch"); // RULE3

   property p_clear;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      cnt_ctl_ff[0] |=> (acc_ff[0] == 32'h00000000);
   endproperty
   a_clear: assert property (p_clear) else $error("counter one not cleared"); // RULE11

   property p_zero_duty;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (pwm_set[0].duty == 32'h00000000) [*2] |-> !pwm_raw[0];
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("output on at zero duty"); // RULE6

   property p_full_duty;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (pwm_en[0] && pwm_set[0].duty == `DPO_DUTY_FULL && pwm_set[0].freq != 32'h00000000) [*2]
      |-> pwm_raw[0];
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("output off at full duty"); // RULE6

   property p_unloaded;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (pwm_set[1].freq == 32'h00000000) [*2] |-> !pwm_raw[1];
   endproperty
   a_unloaded: assert property (p_unloaded) else $error("output on without period"); // RULE8

   property p_disabled;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      !pwm_en[1] [*2] |-> !pwm_raw[1];
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled modulator active"); // RULE4

   property p_hold;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (hold_ff[0] && ctrl_ff[1:0] == 2'b01) |=> $stable(output_channel_one_o);
   endproperty
   a_hold: assert property (p_hold) else $error("held output changed"); // RULE9

   property p_stop_zero;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (stop_s2_ff && sduty_ff[1] == 32'h00000000) [*2] |-> !pwm_raw[1];
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("stop output high at zero"); // RULE10

   // counter, compare, mux and read paths, each checked one cycle after the decision that drives them
   sequence s_quad1_set;
      cnt_ctl_ff[1] && !cnt_ctl_ff[0] && ctrl_ff[`DPO_CTRL_QUAD1_BIT];
   endsequence

   property p_quad_set;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      s_quad1_set |=> (acc_ff[0] == $past(cpr_ff[0]) - 32'h00000001);
   endproperty
   a_quad_set: assert property (p_quad_set) else $error("quadrature set value wrong"); // RULE13

   property p_clear_three;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      cnt_ctl_ff[2] |=> (acc_ff[2] == 32'h00000000);
   endproperty
   a_clear_three: assert property (p_clear_three) else $error("counter three not cleared"); // RULE11

   property p_cmp_on;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (preset_ff[0] != 32'h00000000 && acc_ff[0] >= preset_ff[0]) |=> cmp_raw[0];
   endproperty
   a_cmp_on: assert property (p_cmp_on) else $error("compare low at preset"); // RULE2

   property p_cmp_below;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (acc_ff[0] < preset_ff[0]) |=> !cmp_raw[0];
   endproperty
   a_cmp_below: assert property (p_cmp_below) else $error("compare high below preset"); // RULE2

   property p_cmp_pin;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ctrl_ff[3:2] == 2'b10) |=> (output_channel_two_o == $past(cmp_raw[1]));
   endproperty
   a_cmp_pin: assert property (p_cmp_pin) else $error("compare mode pin mismatch"); // RULE2

   property p_pwm_pin;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ctrl_ff[1:0] == 2'b01 && !hold_ff[0]) |=> (output_channel_one_o == $past(pwm_raw[0]));
   endproperty
   a_pwm_pin: assert property (p_pwm_pin) else $error("modulated pin mismatch"); // RULE4

   property p_plain_two;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ctrl_ff[3:2] == 2'b00) |=> (output_channel_two_o == $past(ctrl_ff[`DPO_CTRL_PLAIN2_BIT]));
   endproperty
   a_plain_two: assert property (p_plain_two) else $error("plain mode pin two mismatch"); // RULE3

   property p_rsvd;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (ctrl_ff[1:0] == 2'b11) |=> !output_channel_one_o;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("unused mode drives pin high"); // RULE1

   property p_rd_idle;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      !bus_i.rd |=> (rdata_o == 32'h00000000);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule
`default_nettype wire

// file: dv/dpo_load.sv
// load model on one output pin: counts high samples and rising edges
`timescale 1ns/1ps
`default_nettype none
module dpo_load (
   input wire logic clk_sys_i,
   input wire logic clr_i,
   input wire logic pin_i,
   output logic [15:0] high_o,
   output logic [15:0] rise_o
);
   logic prev_ff;
   // ==========================================
   // measurement
   // a plain load only senses the pin, it never drives it back
   always_ff @(posedge clk_sys_i) begin
      prev_ff <= pin_i;
      if (clr_i) begin
         high_o <= 16'h0000;
         rise_o <= 16'h0000;
      end else begin
         high_o <= high_o + {15'h0, pin_i};
         rise_o <= rise_o + {15'h0, pin_i & ~prev_ff};
      end
   end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the dual output modulator and compare block
`timescale 1ns/1ps
`default_nettype none
`include "dpo_cfg.svh"
module testbench;
   import dpo_pkg::*;
   logic clk_sys_i, rstn_i, stop_mode_i, clr;
   logic [3:0] cnt_inc_i;
   dpo_bus_req_t bus_i;
   logic [31:0] rdata_o;
   logic pin1, pin2;
   logic [15:0] hi1, hi2, ri1, ri2;
   int num_errors = 0;
   int checks_done = 0;
   // ==========================================
   // clock, design and loads
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   dpo_top dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .stop_mode_i(stop_mode_i), .cnt_inc_i(cnt_inc_i), .output_channel_one_o(pin1),
      .output_channel_two_o(pin2));
   dpo_load load1 (.clk_sys_i(clk_sys_i), .clr_i(clr), .pin_i(pin1), .high_o(hi1), .rise_o(ri1));
   dpo_load load2 (.clk_sys_i(clk_sys_i), .clr_i(clr), .pin_i(pin2), .high_o(hi2), .rise_o(ri2));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus_i <= '0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus_i <= '0;
      #1 chk(rdata_o, exp);
   endtask
   // waits out any period in flight, then a window of exactly 1000 cycles
   task automatic meas();
      repeat (450) @(posedge clk_sys_i);
      clr <= 1'b1;
      @(posedge clk_sys_i);
      clr <= 1'b0;
      repeat (1000) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic pins(input logic e1, input logic e2);
      repeat (8) @(posedge clk_sys_i);
      #1 chk({31'h0, pin1}, {31'h0, e1});
      chk({31'h0, pin2}, {31'h0, e2});
   endtask
   // count pulses pass a two-flop sync, so keep them wide
   task automatic pulse(input logic [3:0] m);
      @(posedge clk_sys_i);
      cnt_inc_i <= m;
      repeat (3) @(posedge clk_sys_i);
      cnt_inc_i <= 4'h0;
      repeat (3) @(posedge clk_sys_i);
   endtask
   task automatic conclude();
      if (num_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      rd(`DPO_OFS_CTRL, `DPO_CTRL_RESET);
      rd(`DPO_OFS_DUTY1, `DPO_REG_RESET);
      rd(`DPO_OFS_FREQ1, `DPO_REG_RESET);
      rd(`DPO_OFS_PRESET1, `DPO_REG_RESET);
      rd(8'h3c, 32'h0);
      wr(`DPO_OFS_ACC1, 32'h55);
      rd(`DPO_OFS_ACC1, 32'h0);
      pins(1'b0, 1'b0);
   endtask
   task automatic t_unloaded();
      wr(`DPO_OFS_CTRL, 32'h00c5);
      wr(`DPO_OFS_DUTY1, 32'd16000);
      wr(`DPO_OFS_FREQ2, 32'd200000);
      meas();
      chk({16'h0, hi1}, 32'd0);
      chk({16'h0, hi2}, 32'd0);
   endtask
   task automatic t_pwm();
      wr(`DPO_OFS_FREQ1, 32'd200000);
      wr(`DPO_OFS_DUTY1, 32'd8000);
      wr(`DPO_OFS_FREQ2, 32'd100000);
      wr(`DPO_OFS_DUTY2, 32'd24000);
      rd(`DPO_OFS_DUTY1, 32'd8000);
      meas();
      chk({16'h0, hi1}, 32'd250);
      chk({16'h0, ri1}, 32'd10);
      chk({16'h0, hi2}, 32'd750);
      wr(`DPO_OFS_DUTY1, 32'd32000);
      wr(`DPO_OFS_DUTY2, 32'd0);
      meas();
      chk({16'h0, hi1}, 32'd1000);
      chk({16'h0, hi2}, 32'd0);
      wr(`DPO_OFS_DUTY1, 32'd40000);
      wr(`DPO_OFS_DUTY2, 32'd16000);
      meas();
      chk({16'h0, hi1}, 32'd1000);
      chk({16'h0, hi2}, 32'd500);
      wr(`DPO_OFS_DUTY1, 32'd8000);
      wr(`DPO_OFS_CTRL, 32'h0045);
      meas();
      chk({16'h0, hi1}, 32'd250);
      chk({16'h0, hi2}, 32'd0);
   endtask
   task automatic t_stop();
      wr(`DPO_OFS_CTRL, 32'h01c5);
      wr(`DPO_OFS_DUTY1, 32'd16000);
      wr(`DPO_OFS_DUTY2, 32'd8000);
      wr(`DPO_OFS_FREQ2, 32'd200000);
      wr(`DPO_OFS_STOP_FREQ2, 32'd200000);
      wr(`DPO_OFS_STOP_DUTY2, 32'd16000);
      stop_mode_i <= 1'b1;
      meas();
      chk({16'h0, ri1}, 32'd0);
      chk({31'h0, hi1 == 16'd0 || hi1 == 16'd1000}, 32'd1);
      chk({16'h0, hi2}, 32'd500);
      wr(`DPO_OFS_STOP_DUTY2, 32'd0);
      meas();
      chk({16'h0, hi2}, 32'd0);
      wr(`DPO_OFS_STOP_DUTY2, 32'd16000);
      wr(`DPO_OFS_STOP_FREQ2, 32'd0);
      meas();
      chk({16'h0, hi2}, 32'd0);
      stop_mode_i <= 1'b0;
      meas();
      chk({16'h0, hi1}, 32'd500);
      chk({16'h0, hi2}, 32'd250);
   endtask
   task automatic t_plain();
      wr(`DPO_OFS_CTRL, 32'h0010);
      pins(1'b1, 1'b0);
      rd(`DPO_OFS_STATUS, 32'h00000002);
      wr(`DPO_OFS_CTRL, 32'h0020);
      pins(1'b0, 1'b1);
      wr(`DPO_OFS_CTRL, 32'h0033);
      pins(1'b0, 1'b1);
   endtask
   task automatic t_count();
      wr(`DPO_OFS_CTRL, 32'h0000);
      wr(`DPO_OFS_CNT_CTRL, 32'hf);
      pulse(4'hf);
      pulse(4'hf);
      for (int i = 0; i < 4; i++) begin
         rd(`DPO_OFS_ACC1 + 8'(4 * i), 32'd2);
         wr(`DPO_OFS_CNT_CTRL, 32'h1 << i);
         rd(`DPO_OFS_ACC1 + 8'(4 * i), 32'd0);
      end
      wr(`DPO_OFS_CTRL, 32'h0c00);
      wr(`DPO_OFS_CPR1, 32'd1024);
      wr(`DPO_OFS_CPR2, 32'd8);
      wr(`DPO_OFS_CNT_CTRL, 32'h2);
      rd(`DPO_OFS_ACC1, 32'd1023);
      wr(`DPO_OFS_CNT_CTRL, 32'h8);
      rd(`DPO_OFS_ACC3, 32'd7);
      wr(`DPO_OFS_CNT_CTRL, 32'h1);
      rd(`DPO_OFS_ACC1, 32'd0);
   endtask
   task automatic t_cmp();
      wr(`DPO_OFS_CTRL, 32'h000a);
      wr(`DPO_OFS_CNT_CTRL, 32'hf);
      wr(`DPO_OFS_PRESET1, 32'd3);
      wr(`DPO_OFS_PRESET2, 32'd0);
      pulse(4'h1);
      pulse(4'h1);
      pins(1'b0, 1'b0);
      pulse(4'h3);
      pins(1'b1, 1'b0);
      wr(`DPO_OFS_PRESET2, 32'd1);
      pins(1'b1, 1'b1);
      wr(`DPO_OFS_PRESET1, 32'd0);
      pins(1'b0, 1'b1);
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      rstn_i = 1'b0;
      bus_i = '0;
      stop_mode_i = 1'b0;
      cnt_inc_i = 4'h0;
      clr = 1'b0;
      repeat (12) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      t_reset();
      t_unloaded();
      t_pwm();
      t_stop();
      t_plain();
      t_count();
      t_cmp();
      conclude();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
